// File: logic/bwuc_top.sv
// Purpose: wiper counter, lock, recall and nonvolatile store control
// Assumes: serial protocol decode outside delivers one-cycle event pulses
// Notes: analog path is represented only by tap select and shutdown force
// Notes: there is no reset pin on the part; rst stands for power-up only
// Notes: every pin is seen four to five clocks late through the filters
`timescale 1ns/100ps

// Functional notes
// - Wiper position held in counter decoded to one of 256 taps.
// - Counter saturates at both ends and never wraps.
// - With enable and SDA high, outside shutdown and armed, each serial clock falling edge steps the wiper once.
// - Direction and clock steps honoured only while enable is high.
// - SDA high and enable high: direction high increments, low decrements.
// - Enable high and direction toggle latches wiper into volatile register.
// - At power-up the nonvolatile value loads into the wiper register.
// - Delivered stored wiper value is position zero.
// - A bus byte write also commits the wiper to nonvolatile storage.
// - Falling enable after that STOP, clock low, starts nonvolatile write.
// - Pin store saves both reference and bias wiper positions.
// - After shutdown release, enable must cycle once before stepping.
// - Direction output is open drain, high when current below target.
// - Direction low with enable and clock moves toward low terminal.
// - Shutdown forces bias output to ground, release restores held wiper.
// - Enable low holds the wiper; clock serves only the serial bus.
// - Status register at 0Fh reports shutdown, direction, enable, latch, gain.
module bwuc_top #(
  parameter int NV_WRITE_CYCLES = bwuc_pkg::NV_WRITE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire bwuc_pkg::bwuc_pins_t pins,
  input wire bwuc_pkg::bwuc_bus_ev_t bus_ev,
  input wire logic [bwuc_pkg::REF_W-1:0] ref_wiper,
  input wire logic comp_above,
  output logic [255:0] tap_sel,
  output logic [bwuc_pkg::WIPER_W-1:0] wiper_count_register,
  output logic bias_force_gnd,
  output logic dir_o,
  output logic dir_oe,
  output logic [7:0] status_reg,
  output logic wiper_lock_event,
  output logic nv_busy,
  output logic [bwuc_pkg::WIPER_W-1:0] nv_bias_q,
  output logic [bwuc_pkg::REF_W-1:0] nv_ref_q
);
  import bwuc_pkg::*;

  // Three-stage synchronisers; only stages two and three are compared
  // Stage one may go metastable, so nothing but stage two ever reads it
  logic [2:0] scl_s, sda_s, cal_s, shut_s, dir_s;
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_s <= 3'h0;
      sda_s <= 3'h0;
      cal_s <= 3'h0;
      shut_s <= 3'h0;
      dir_s <= 3'h0;
    end else begin
      scl_s <= {scl_s[1:0], pins.scl};
      sda_s <= {sda_s[1:0], pins.sda};
      cal_s <= {cal_s[1:0], pins.cal_en};
      shut_s <= {shut_s[1:0], pins.bias_shutdown};
      dir_s <= {dir_s[1:0], pins.dir};
    end
  end

  // Filtered levels update only when stages two and three agree
  // A one-sample glitch on a pin is thereby dropped, at one clock of latency
  logic scl_f, sda_f, cal_f, shut_f, dir_f;
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_f <= 1'b0;
      sda_f <= 1'b0;
      cal_f <= 1'b0;
      shut_f <= 1'b0;
      dir_f <= 1'b0;
    end else begin
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      if (cal_s[1] == cal_s[2]) cal_f <= cal_s[2];
      if (shut_s[1] == shut_s[2]) shut_f <= shut_s[2];
      if (dir_s[1] == dir_s[2]) dir_f <= dir_s[2];
    end
  end

  // Edge detection on filtered levels
  // Reset values are low, so an idle-high pin shows only a rise after
  // power-up; none of the falling-edge events can fire falsely then
  logic scl_p, cal_p, shut_p, dir_p;
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_p <= 1'b0;
      cal_p <= 1'b0;
      shut_p <= 1'b0;
      dir_p <= 1'b0;
    end else begin
      scl_p <= scl_f;
      cal_p <= cal_f;
      shut_p <= shut_f;
      dir_p <= dir_f;
    end
  end

  // One-cycle event strobes, all in the mclk domain
  logic scl_fall, cal_rise, cal_fall, shut_rel, dir_toggle;
  assign scl_fall = scl_p & ~scl_f;
  assign cal_rise = ~cal_p & cal_f;
  assign cal_fall = cal_p & ~cal_f;
  assign shut_rel = shut_p & ~shut_f;
  // Either direction of change counts as a toggle
  assign dir_toggle = dir_p ^ dir_f;

  // Stepping stays blocked after shutdown release until enable cycles once
  typedef enum logic [1:0] {ARM_READY, ARM_WAIT_LOW, ARM_WAIT_HIGH} bwuc_arm_t;
  bwuc_arm_t arm_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      arm_q <= ARM_READY;
    end else begin
      case (arm_q)
        ARM_READY: if (shut_rel) arm_q <= ARM_WAIT_LOW;
        ARM_WAIT_LOW: if (cal_fall || !cal_f) arm_q <= ARM_WAIT_HIGH;
        ARM_WAIT_HIGH: if (cal_rise) arm_q <= ARM_READY;
        default: arm_q <= ARM_READY;
      endcase
    end
  end

  logic step_ok;
  // Enable, SDA idle high, not shut down, and armed
  // SDA low keeps a bus START from moving the wiper while enable is high
  // Trade-off: stepping is also held off during shutdown, though the
  // counter would be invisible there, so release never shows a jump
  assign step_ok = cal_f & sda_f & ~shut_f & (arm_q == ARM_READY);

  // Nonvolatile image: delivered value zero; recall at power-up via reset
  logic recall_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      recall_q <= 1'b1;
    end else begin
      recall_q <= 1'b0;
    end
  end

  // Wiper counter, saturating; low direction walks toward the low terminal
  logic [WIPER_W-1:0] wiper_d;
  always_comb begin
    wiper_d = wiper_count_register;
    if (recall_q) begin
      wiper_d = nv_bias_q;
    end else if (step_ok && scl_fall) begin
      if (dir_f && wiper_count_register != WIPER_MAX) begin
        wiper_d = wiper_count_register + 8'h01;
      end else if (!dir_f && wiper_count_register != WIPER_MIN) begin
        wiper_d = wiper_count_register - 8'h01;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wiper_count_register <= WIPER_MIN;
    end else begin
      wiper_count_register <= wiper_d;
    end
  end

  // One-hot tap select from the counter
  // Decoded from the next value so taps and counter change on one edge
  // Break-before-make is left to the analog switches
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_tap
      localparam logic [WIPER_W-1:0] TAP_IDX = WIPER_W'(gi);
      always_ff @(posedge mclk) begin
        if (rst) begin
          tap_sel[gi] <= 1'b0;
        end else begin
          tap_sel[gi] <= (wiper_d == TAP_IDX);
        end
      end
    end
  endgenerate

  // Direction toggle with enable high latches the volatile wiper
  logic [WIPER_W-1:0] lock_wiper_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      wiper_lock_event <= 1'b0;
      lock_wiper_q <= WIPER_MIN;
    end else begin
      wiper_lock_event <= cal_f & dir_toggle;
      if (cal_f && dir_toggle) lock_wiper_q <= wiper_count_register;
    end
  end

  // Write enable latch and gain bit, written over the serial bus
  logic write_enable_latch, gain_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
      gain_q <= 1'b0;
    end else begin
      if (bus_ev.wel_write) write_enable_latch <= bus_ev.wel_value;
      if (bus_ev.gain_write) gain_q <= bus_ev.gain_value;
    end
  end

  // Armed once an address-only write ends in STOP with enable high
  logic store_armed_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      store_armed_q <= 1'b0;
    end else if (bus_ev.addr_only_stop && cal_f) begin
      store_armed_q <= 1'b1;
    end else if (cal_fall || (scl_fall && !cal_f)) begin
      store_armed_q <= 1'b0;
    end
  end

  // Store start: pin sequence or bus byte write, gated by the latch
  logic store_go, nv_done;
  assign store_go = write_enable_latch & ~nv_busy &
                    ((store_armed_q & cal_fall & ~scl_f) | bus_ev.byte_write);

  // Self-timed write: counter holds busy for the full cycle time
  // Busy stands NV_WRITE_CYCLES clocks; a new store is refused meanwhile
  // Limitation: no acknowledge polling; the bus side must wait it out
  logic [$clog2(NV_WRITE_CYCLES+1)-1:0] nv_cnt_q;
  assign nv_done = nv_busy && (nv_cnt_q == '0);
  always_ff @(posedge mclk) begin
    if (rst) begin
      nv_busy <= 1'b0;
      nv_cnt_q <= '0;
    end else if (store_go) begin
      nv_busy <= 1'b1;
      nv_cnt_q <= ($clog2(NV_WRITE_CYCLES+1))'(NV_WRITE_CYCLES - 1);
    end else if (nv_busy) begin
      if (nv_done) nv_busy <= 1'b0;
      else nv_cnt_q <= nv_cnt_q - 1'b1;
    end
  end

  // Both wipers captured at store start; power loss mid-write is not modelled
  always_ff @(posedge mclk) begin
    if (rst) begin
      nv_bias_q <= NV_WIPER_RST;
      nv_ref_q <= NV_REF_RST;
    end else if (store_go) begin
      nv_bias_q <= wiper_count_register;
      nv_ref_q <= ref_wiper;
    end
  end

  // Shutdown forces output to ground; counter untouched so release restores
  always_ff @(posedge mclk) begin
    if (rst) begin
      bias_force_gnd <= 1'b0;
    end else begin
      bias_force_gnd <= shut_f;
    end
  end

  // Open drain direction: enable asserted only to pull low
  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_o <= 1'b0;
      dir_oe <= 1'b0;
    end else begin
      dir_o <= 1'b0;
      dir_oe <= comp_above;
    end
  end

  // Status image at address 0Fh; test bits read zero
  // Pin bits show the filtered levels, so they lag the pins slightly
  // The serial read path outside samples this image when it shifts out
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= 8'h00;
      status_reg[SR_SHUT_BIT] <= shut_f;
      status_reg[SR_DIR_BIT] <= dir_f;
      status_reg[SR_CAL_BIT] <= cal_f;
      status_reg[SR_LATCH_BIT] <= write_enable_latch;
      status_reg[SR_GAIN_BIT] <= gain_q;
    end
  end
endmodule

// File: logic/bwuc_pkg.sv
// Purpose: shared constants and carrier types for the bias wiper up/down control
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: nonvolatile storage is modelled as held registers behind a store strobe
package bwuc_pkg;
  localparam int WIPER_W = 8;
  localparam int REF_W = 6;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [7:0] WIPER_MAX = 8'hFF;
  localparam logic [7:0] NV_WIPER_RST = 8'h00;  // Delivered stored position
  localparam logic [5:0] NV_REF_RST = 6'h00;
  localparam logic [3:0] STATUS_ADDR = 4'hF;
  localparam logic [7:0] LATCH_SET_VALUE = 8'h02;
  localparam int SR_SHUT_BIT = 7;
  localparam int SR_DIR_BIT = 6;
  localparam int SR_CAL_BIT = 4;
  localparam int SR_LATCH_BIT = 1;
  localparam int SR_GAIN_BIT = 0;
  localparam int CLK_MHZ = 25;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;

  // Raw pins from the host side, synchronised inside bwuc_top
  typedef struct packed {
    logic scl;
    logic sda;
    logic cal_en;
    logic bias_shutdown;
    logic dir;
  } bwuc_pins_t;

  // Decoded events from the serial front end
  typedef struct packed {
    logic byte_write;
    logic addr_only_stop;
    logic wel_write;
    logic wel_value;
    logic gain_write;
    logic gain_value;
  } bwuc_bus_ev_t;
endpackage

// File: tb/bwuc_chk.sv
// Purpose: port-level assertions for the bias wiper control
// Assumes: bound to bwuc_top; pins reach the core about five clocks late
// Notes: pin-driven checks wait 8 stable samples to cover sync latency
`timescale 1ns/100ps
module bwuc_chk #(
  parameter int NV_WRITE_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire bwuc_pkg::bwuc_pins_t pins,
  input wire logic [5:0] ref_wiper,
  input wire logic comp_above,
  input wire logic [255:0] tap_sel,
  input wire logic [7:0] wiper_count_register,
  input wire logic bias_force_gnd,
  input wire logic dir_o,
  input wire logic dir_oe,
  input wire logic [7:0] status_reg,
  input wire logic nv_busy,
  input wire logic [7:0] nv_bias_q,
  input wire logic [5:0] nv_ref_q
);
  import bwuc_pkg::*;
  int busy_len_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Count busy cycles so the store length is checked without long repetitions
  always_ff @(posedge mclk) begin
    busy_len_q <= (rst || !nv_busy) ? 0 : busy_len_q + 1;
  end
  chk_tap_onehot: assert property (!$past(rst) |-> tap_sel == (256'h1 << wiper_count_register))
    else $error("tap select not matching wiper");
  chk_single_step: assert property (!$past(rst) |->
    8'(wiper_count_register - $past(wiper_count_register)) inside {8'h00, 8'h01, 8'hff})
    else $error("wiper moved more than one tap");
  chk_no_wrap_top: assert property (wiper_count_register == 8'hff |=> wiper_count_register != 8'h00)
    else $error("wiper wrapped upward");
  chk_no_wrap_low: assert property (wiper_count_register == 8'h00 |=> wiper_count_register != 8'hff)
    else $error("wiper wrapped downward");
  chk_hold_disabled: assert property ((!pins.cal_en)[*8] |-> $stable(wiper_count_register))
    else $error("wiper moved with enable low");
  chk_shut_ground: assert property (pins.bias_shutdown[*8] |->
    bias_force_gnd && status_reg[SR_SHUT_BIT])
    else $error("shutdown not forcing ground");
  chk_shut_release: assert property ((!pins.bias_shutdown)[*8] |-> !bias_force_gnd)
    else $error("ground forced without shutdown");
  chk_dir_drive: assert property (comp_above[*8] |-> dir_oe && !dir_o)
    else $error("direction line not pulled low");
  chk_dir_release: assert property ((!comp_above)[*8] |-> !dir_oe)
    else $error("direction line driven while below target");
  chk_store_len: assert property ($fell(nv_busy) |-> busy_len_q == NV_WRITE_CYCLES)
    else $error("store busy length wrong");
  chk_store_both: assert property ($rose(nv_busy) |->
    nv_bias_q == wiper_count_register && nv_ref_q == ref_wiper)
    else $error("store did not capture both wipers");
  chk_status_zero: assert property (status_reg[5] == 1'b0 && status_reg[3:2] == 2'b00)
    else $error("reserved status bits set");
endmodule

// File: tb/bwuc_host.sv
// Purpose: host serial clock source for wiper stepping
// Assumes: run and idle change just after a clock edge
// Notes: one clock period is eight mclk cycles, starting at the idle level
`timescale 1ns/100ps
module bwuc_host (
  input wire logic mclk,
  input wire logic run,
  input wire logic idle,
  output logic scl
);
  logic [1:0] cnt_q;
  // Parked at the idle level outside bursts; low park readies a pin store
  always_ff @(posedge mclk) begin
    cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
    if (!run) begin
      scl <= idle;
    end else if (cnt_q == 2'h3) begin
      scl <= ~scl;
    end
  end
endmodule

// File: tb/tb_bias_wiper_updown_control.sv
// Purpose: directed sequences for stepping, lock, shutdown and store
// Assumes: short store time of 20 cycles for simulation
// Notes: each step burst is eight mclk per serial clock period
`timescale 1ns/100ps
module tb_bias_wiper_updown_control;
  import bwuc_pkg::*;
  logic mclk = 0, rst = 1, run = 0, idle = 1, scl, sda = 1, cal = 0, shut = 0, dir = 1;
  logic comp_above = 0, force_gnd, dir_o, dir_oe, lock, nv_busy;
  logic [5:0] ref_wiper = 6'h2a, nv_ref_q;
  logic [7:0] wiper, status_reg, nv_bias_q;
  logic [255:0] tap_sel;
  bwuc_pins_t pins;
  bwuc_bus_ev_t bus_ev = '0;
  int mismatches = 0, comparisons = 0, cycles = 0, locks = 0;
  assign pins = '{scl: scl, sda: sda, cal_en: cal, bias_shutdown: shut, dir: dir};
  always #20 mclk = ~mclk;
  bwuc_host i_host (.mclk(mclk), .run(run), .idle(idle), .scl(scl));
  bwuc_top #(.NV_WRITE_CYCLES(20)) i_dut (.mclk(mclk), .rst(rst), .pins(pins),
    .bus_ev(bus_ev), .ref_wiper(ref_wiper), .comp_above(comp_above), .tap_sel(tap_sel),
    .wiper_count_register(wiper), .bias_force_gnd(force_gnd), .dir_o(dir_o), .dir_oe(dir_oe),
    .status_reg(status_reg), .wiper_lock_event(lock), .nv_busy(nv_busy),
    .nv_bias_q(nv_bias_q), .nv_ref_q(nv_ref_q));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Burst of n serial clock falls, then settle past the sync latency
  task automatic step(input int n);
    run <= 1;
    wt(8 * n);
    run <= 0;
    wt(12);
  endtask
  task automatic ev(input bwuc_bus_ev_t e);
    @(posedge mclk) bus_ev <= e;
    @(posedge mclk) bus_ev <= '0;
  endtask
  // Hang guard well above the ~4500 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (lock === 1'b1) locks++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    wt(8);
    rst <= 0;
    wt(4);
    chk(wiper, 0);
    chk(tap_sel, 1);
    cal <= 1;
    wt(8);
    step(3);
    chk(tap_sel, 256'h1 << 3);
    dir <= 0;
    step(1);
    chk(wiper, 2);
    chk(locks, 1);
    sda <= 0;
    step(2);
    chk(wiper, 2);
    sda <= 1;
    cal <= 0;
    step(2);
    chk(wiper, 2);
    cal <= 1;
    dir <= 1;
    step(260);
    chk(wiper, 8'hff);
    dir <= 0;
    step(258);
    chk(wiper, 0);
    comp_above <= 1;
    shut <= 1;
    wt(10);
    chk({dir_oe, dir_o, force_gnd, status_reg[SR_SHUT_BIT]}, 4'hb);
    shut <= 0;
    comp_above <= 0;
    dir <= 1;
    step(2);
    chk({force_gnd, wiper}, 0);
    cal <= 0;
    wt(8);
    cal <= 1;
    wt(8);
    step(2);
    chk(wiper, 2);
    chk(status_reg[SR_CAL_BIT], 1);
    // Host sets the latch, then sends the address-only write with enable high
    ev(6'h0c);
    ev(6'h10);
    chk({status_reg[SR_DIR_BIT], status_reg[SR_LATCH_BIT]}, 2'b11);
    chk(locks != 0, 1);
    sda <= 0;
    idle <= 0;
    wt(8);
    cal <= 0;
    for (int i = 0; i < 50 && nv_busy !== 1'b1; i++) wt(1);
    chk({nv_busy, nv_bias_q, nv_ref_q}, {1'b1, 8'h02, 6'h2a});
    wt(40);
    chk(nv_busy, 0);
    // Latch cleared: a bus byte write must not start a store
    ev(6'h08);
    sda <= 1;
    cal <= 1;
    step(1);
    ev(6'h20);
    wt(2);
    chk({nv_busy, nv_bias_q}, {1'b0, 8'h02});
    // Latch set again: the byte write commits the moved wiper
    ev(6'h0c);
    ev(6'h20);
    wt(2);
    chk({nv_busy, nv_bias_q, wiper}, {1'b1, 8'h03, 8'h03});
    ev(6'h03);
    wt(2);
    chk(status_reg[SR_GAIN_BIT], 1);
    end_sim();
  end
endmodule
bind bwuc_top bwuc_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_chk (.mclk(mclk), .rst(rst),
  .pins(pins), .ref_wiper(ref_wiper), .comp_above(comp_above), .tap_sel(tap_sel),
  .wiper_count_register(wiper_count_register), .bias_force_gnd(bias_force_gnd),
  .dir_o(dir_o), .dir_oe(dir_oe), .status_reg(status_reg), .nv_busy(nv_busy),
  .nv_bias_q(nv_bias_q), .nv_ref_q(nv_ref_q));
